// file: vpsl_defines.vh
// Constants for the voltage protection stage logic.
`ifndef VPSL_DEFINES_VH
`define VPSL_DEFINES_VH

`define VPSL_CLK_NS 5
`define VPSL_TICK_NS 1000000

`define VPSL_OFS_CTRL 8'h00
`define VPSL_OFS_ROUTE 8'h04
`define VPSL_OFS_LS_THR 8'h08
`define VPSL_OFS_LS_TIME 8'h0C
`define VPSL_OFS_HS_THR 8'h10
`define VPSL_OFS_HS_TIME 8'h14
`define VPSL_OFS_OV_THR 8'h18
`define VPSL_OFS_OV_TIME 8'h1C
`define VPSL_OFS_UV_THR 8'h20
`define VPSL_OFS_UV_TIME 8'h24
`define VPSL_OFS_NOMINAL 8'h28
`define VPSL_OFS_STATUS 8'h2C
`define VPSL_OFS_REC_TRIG 8'h30
`define VPSL_OFS_REC_CTRL 8'h34
`define VPSL_OFS_REC_IDX 8'h38
`define VPSL_OFS_REC_DATA 8'h3C

`define VPSL_CTRL_DVB_BIT 0
`define VPSL_CTRL_SGB5_BIT 4
`define VPSL_REC_CTRL_REARM_BIT 0

`define VPSL_RST_CTRL 8'h00
`define VPSL_RST_ROUTE 8'hFF
`define VPSL_RST_LS_THR 12'h200
`define VPSL_RST_HS_THR 12'h600
`define VPSL_RST_OV_THR 12'hA00
`define VPSL_RST_UV_THR 12'h600
`define VPSL_RST_TIME 16'h0064
`define VPSL_RST_NOMINAL 12'h800
`define VPSL_RST_REC_TRIG 4'hF
`define VPSL_RST_REC_POST 4'h8

`define VPSL_DEAD_DIV 12'h005

`define VPSL_REC_IDLE 2'h0
`define VPSL_REC_POST 2'h1
`define VPSL_REC_DONE 2'h2

`endif

// file: vpsl_stage.v
// One protection stage: start on threshold condition, trip when the operating timer expires.
`timescale 1ns/100ps
module vpsl_stage #(
    parameter TW = 16
) (
    input wire clk,
    input wire arst_n,
    input wire tick,
    input wire cond,
    input wire block,
    input wire trip_inh,
    input wire [TW-1:0] op_time,
    output wire start,
    output wire trip
);
    reg start_r;
    reg trip_r;
    reg [TW-1:0] cnt_r;

    assign start = start_r;
    assign trip = trip_r;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            start_r <= 1'b0;
            trip_r <= 1'b0;
            cnt_r <= {TW{1'b0}};
        end else if (!cond || block) begin
            // Condition gone before expiry: timer cleared, no trip. [RQ17]
            start_r <= 1'b0;
            trip_r <= 1'b0;
            cnt_r <= {TW{1'b0}};
        end else begin
            // Start held while the condition lasts. [RQ18]
            start_r <= 1'b1;
            if (start_r && tick && cnt_r != op_time) begin
                cnt_r <= cnt_r + {{(TW-1){1'b0}}, 1'b1};
            end
            trip_r <= start_r && (cnt_r == op_time) && !trip_inh;
        end
    end
endmodule

// file: vpsl_top.v
// Busbar voltage supervision: four stages, output relay routing and disturbance recorder.
`timescale 1ns/100ps
`include "vpsl_defines.vh"
//
// Summary of operation
// (RQ1) Residual above low-set threshold raises start and launches its timer together.
// (RQ2) Low-set residual trips when its timer reaches operating time while started.
// (RQ3) High-set residual stage works the same with its own threshold and time.
// (RQ4) Overvoltage starts when any phase-to-phase voltage exceeds threshold; trips after time.
// (RQ5) Undervoltage starts when any phase-to-phase voltage drops below threshold; trips after time.
// (RQ6) Dead-voltage switch set suppresses undervoltage start and trip below 0.2 nominal.
// (RQ7) External block inhibits only the undervoltage trip, nothing else.
// (RQ8) External block acts only when blocking switch 5 is set.
// (RQ9) Relay A energised by trip of any of the four stages.
// (RQ10) Relay B driven by high-set residual, overvoltage and undervoltage stages.
// (RQ11) Relay C follows overvoltage, D undervoltage, E low-set residual.
// (RQ12) Supervision relay holds normal contacts when healthy, alternate contacts on fault.
// (RQ13) Recorder captures residual and phase voltage with all starts on trigger.
// (RQ14) Recorder keeps samples from before and after the trigger.
// (RQ15) Records readable through the serial readout port or the register port.
// (RQ16) Relay B trip and B/D start paths gated by routing switches, default set.
// (RQ17) Stage condition ceasing before expiry drops start and clears timer, no trip.
// (RQ18) Each stage has separate start and trip; start held while condition persists.
module vpsl_top #(
    parameter VW = 12,
    parameter TW = 16,
    parameter DEPTH = 16,
    parameter IW = 4,
    parameter [23:0] TICK_CYCLES = `VPSL_TICK_NS / `VPSL_CLK_NS
) (
    input wire MCLK,
    input wire ARST_N,
    input wire [7:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output wire [31:0] RDATA,
    input wire [VW-1:0] U0_IN,
    input wire [VW-1:0] U12_IN,
    input wire [VW-1:0] U23_IN,
    input wire [VW-1:0] U31_IN,
    input wire EXTERNAL_BLOCK_IN,
    input wire INTERNAL_FAULT_IN,
    output wire RESIDUAL_LOW_START_OUT,
    output wire RESIDUAL_LOW_TRIP_OUT,
    output wire RESIDUAL_HIGH_START_OUT,
    output wire RESIDUAL_HIGH_TRIP_OUT,
    output wire OVERVOLTAGE_START_OUT,
    output wire OVERVOLTAGE_TRIP_OUT,
    output wire UNDERVOLTAGE_START_OUT,
    output wire UNDERVOLTAGE_TRIP_OUT,
    output wire RELAY_A,
    output wire RELAY_B,
    output wire RELAY_C,
    output wire RELAY_D,
    output wire RELAY_E,
    output wire SUPV_NORMAL_CLOSED,
    output wire SUPV_FAULT_CLOSED,
    output wire INTERNAL_FAULT_ALARM,
    output wire REC_ACTIVE,
    output wire REC_STORED,
    input wire [IW-1:0] SER_IDX,
    output wire [31:0] SER_DATA
);
    localparam EW = 4 + 2 * VW;

    // ------------------------------------------------------------
    // Settings registers
    // ------------------------------------------------------------
    reg [7:0] ctrl_r;
    reg [7:0] route_r;
    reg [VW-1:0] ls_thr_r;
    reg [VW-1:0] hs_thr_r;
    reg [VW-1:0] ov_thr_r;
    reg [VW-1:0] uv_thr_r;
    reg [TW-1:0] ls_time_r;
    reg [TW-1:0] hs_time_r;
    reg [TW-1:0] ov_time_r;
    reg [TW-1:0] uv_time_r;
    reg [VW-1:0] nominal_r;
    reg [3:0] rec_trig_r;
    reg [IW-1:0] rec_post_r;
    reg [IW-1:0] rec_idx_r;
    reg rearm_r;
    reg [31:0] rdata_r;

    wire dvb_sw = ctrl_r[`VPSL_CTRL_DVB_BIT];
    wire sgb5_sw = ctrl_r[`VPSL_CTRL_SGB5_BIT];

    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_r <= `VPSL_RST_CTRL;
            route_r <= `VPSL_RST_ROUTE;
            ls_thr_r <= `VPSL_RST_LS_THR;
            hs_thr_r <= `VPSL_RST_HS_THR;
            ov_thr_r <= `VPSL_RST_OV_THR;
            uv_thr_r <= `VPSL_RST_UV_THR;
            ls_time_r <= `VPSL_RST_TIME;
            hs_time_r <= `VPSL_RST_TIME;
            ov_time_r <= `VPSL_RST_TIME;
            uv_time_r <= `VPSL_RST_TIME;
            nominal_r <= `VPSL_RST_NOMINAL;
            rec_trig_r <= `VPSL_RST_REC_TRIG;
            rec_post_r <= `VPSL_RST_REC_POST;
            rec_idx_r <= {IW{1'b0}};
            rearm_r <= 1'b0;
        end else begin
            rearm_r <= 1'b0;
            if (WR) begin
                case (ADDR)
                    `VPSL_OFS_CTRL: begin
                        ctrl_r <= WDATA[7:0];
                    end
                    `VPSL_OFS_ROUTE: begin
                        route_r <= WDATA[7:0];
                    end
                    `VPSL_OFS_LS_THR: begin
                        ls_thr_r <= WDATA[VW-1:0];
                    end
                    `VPSL_OFS_LS_TIME: begin
                        ls_time_r <= WDATA[TW-1:0];
                    end
                    `VPSL_OFS_HS_THR: begin
                        hs_thr_r <= WDATA[VW-1:0];
                    end
                    `VPSL_OFS_HS_TIME: begin
                        hs_time_r <= WDATA[TW-1:0];
                    end
                    `VPSL_OFS_OV_THR: begin
                        ov_thr_r <= WDATA[VW-1:0];
                    end
                    `VPSL_OFS_OV_TIME: begin
                        ov_time_r <= WDATA[TW-1:0];
                    end
                    `VPSL_OFS_UV_THR: begin
                        uv_thr_r <= WDATA[VW-1:0];
                    end
                    `VPSL_OFS_UV_TIME: begin
                        uv_time_r <= WDATA[TW-1:0];
                    end
                    `VPSL_OFS_NOMINAL: begin
                        nominal_r <= WDATA[VW-1:0];
                    end
                    `VPSL_OFS_REC_TRIG: begin
                        rec_trig_r <= WDATA[3:0];
                        rec_post_r <= WDATA[8+IW-1:8];
                    end
                    `VPSL_OFS_REC_CTRL: begin
                        rearm_r <= WDATA[`VPSL_REC_CTRL_REARM_BIT];
                    end
                    `VPSL_OFS_REC_IDX: begin
                        rec_idx_r <= WDATA[IW-1:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Operating time base
    // ------------------------------------------------------------
    reg [23:0] tick_cnt_r;
    reg tick_r;

    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tick_cnt_r <= 24'h000000;
            tick_r <= 1'b0;
        end else if (tick_cnt_r >= TICK_CYCLES - 24'h000001) begin
            tick_cnt_r <= 24'h000000;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 24'h000001;
            tick_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Stage conditions and blocking
    // ------------------------------------------------------------
    wire [VW-1:0] dead_level = nominal_r / `VPSL_DEAD_DIV;
    wire ls_cond = U0_IN > ls_thr_r; // [RQ1]
    wire hs_cond = U0_IN > hs_thr_r; // [RQ3]
    wire ov_cond = (U12_IN > ov_thr_r) || (U23_IN > ov_thr_r) || (U31_IN > ov_thr_r); // [RQ4]
    wire uv_cond = (U12_IN < uv_thr_r) || (U23_IN < uv_thr_r) || (U31_IN < uv_thr_r); // [RQ5]
    wire all_dead = (U12_IN < dead_level) && (U23_IN < dead_level) && (U31_IN < dead_level);
    wire uv_dead_block = dvb_sw && all_dead; // [RQ6]
    wire uv_trip_inh = sgb5_sw && EXTERNAL_BLOCK_IN; // [RQ7] [RQ8]

    wire ls_start;
    wire ls_trip;
    wire hs_start;
    wire hs_trip;
    wire ov_start;
    wire ov_trip;
    wire uv_start;
    wire uv_trip;

    // Low-set residual stage. [RQ1] [RQ2]
    vpsl_stage #(.TW(TW)) u_ls (
        .clk(MCLK),
        .arst_n(ARST_N),
        .tick(tick_r),
        .cond(ls_cond),
        .block(1'b0),
        .trip_inh(1'b0),
        .op_time(ls_time_r),
        .start(ls_start),
        .trip(ls_trip)
    );

    // High-set residual stage. [RQ3]
    vpsl_stage #(.TW(TW)) u_hs (
        .clk(MCLK),
        .arst_n(ARST_N),
        .tick(tick_r),
        .cond(hs_cond),
        .block(1'b0),
        .trip_inh(1'b0),
        .op_time(hs_time_r),
        .start(hs_start),
        .trip(hs_trip)
    );

    // Phase overvoltage stage. [RQ4]
    vpsl_stage #(.TW(TW)) u_ov (
        .clk(MCLK),
        .arst_n(ARST_N),
        .tick(tick_r),
        .cond(ov_cond),
        .block(1'b0),
        .trip_inh(1'b0),
        .op_time(ov_time_r),
        .start(ov_start),
        .trip(ov_trip)
    );

    // Phase undervoltage stage with dead-voltage and external blocking. [RQ5] [RQ6] [RQ7]
    vpsl_stage #(.TW(TW)) u_uv (
        .clk(MCLK),
        .arst_n(ARST_N),
        .tick(tick_r),
        .cond(uv_cond),
        .block(uv_dead_block),
        .trip_inh(uv_trip_inh),
        .op_time(uv_time_r),
        .start(uv_start),
        .trip(uv_trip)
    );

    // ------------------------------------------------------------
    // Output relays
    // ------------------------------------------------------------
    reg [4:0] relay_r;
    reg fault_r;

    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            relay_r <= 5'h00;
            fault_r <= 1'b0;
        end else begin
            relay_r[0] <= ls_trip || hs_trip || ov_trip || uv_trip; // [RQ9]
            relay_r[1] <= hs_trip || (ov_trip && route_r[4]) || (uv_trip && route_r[5]) ||
                (ov_start && route_r[6]); // [RQ10] [RQ16]
            relay_r[2] <= ov_trip; // [RQ11]
            relay_r[3] <= uv_trip || (uv_start && route_r[7]); // [RQ11] [RQ16]
            relay_r[4] <= ls_trip; // [RQ11]
            fault_r <= INTERNAL_FAULT_IN;
        end
    end

    assign RELAY_A = relay_r[0];
    assign RELAY_B = relay_r[1];
    assign RELAY_C = relay_r[2];
    assign RELAY_D = relay_r[3];
    assign RELAY_E = relay_r[4];
    assign SUPV_NORMAL_CLOSED = !fault_r; // [RQ12]
    assign SUPV_FAULT_CLOSED = fault_r; // [RQ12]
    assign INTERNAL_FAULT_ALARM = fault_r;

    assign RESIDUAL_LOW_START_OUT = ls_start;
    assign RESIDUAL_LOW_TRIP_OUT = ls_trip;
    assign RESIDUAL_HIGH_START_OUT = hs_start;
    assign RESIDUAL_HIGH_TRIP_OUT = hs_trip;
    assign OVERVOLTAGE_START_OUT = ov_start;
    assign OVERVOLTAGE_TRIP_OUT = ov_trip;
    assign UNDERVOLTAGE_START_OUT = uv_start;
    assign UNDERVOLTAGE_TRIP_OUT = uv_trip;

    // ------------------------------------------------------------
    // Disturbance recorder
    // ------------------------------------------------------------
    // The ring runs continuously while idle, so the samples before the
    // trigger are already held when it fires.
    reg [EW-1:0] mem [0:DEPTH-1];
    reg [IW-1:0] wr_ptr_r;
    reg [IW-1:0] post_cnt_r;
    reg [1:0] rec_state_r;
    reg [1:0] rec_state_nxt;
    reg [31:0] ser_data_r;

    wire [3:0] starts = {uv_start, ov_start, hs_start, ls_start};
    wire rec_trigger = |(starts & rec_trig_r); // [RQ13]
    wire rec_write = tick_r && (rec_state_r != `VPSL_REC_DONE);
    wire [IW-1:0] rd_slot = wr_ptr_r + rec_idx_r;
    wire [IW-1:0] ser_slot = wr_ptr_r + SER_IDX;

    always @* begin
        rec_state_nxt = rec_state_r;
        case (rec_state_r)
            `VPSL_REC_IDLE: begin
                if (tick_r && rec_trigger) begin
                    rec_state_nxt = `VPSL_REC_POST;
                end
            end
            `VPSL_REC_POST: begin
                if (tick_r && post_cnt_r == {IW{1'b0}}) begin
                    rec_state_nxt = `VPSL_REC_DONE;
                end
            end
            `VPSL_REC_DONE: begin
                if (rearm_r) begin
                    rec_state_nxt = `VPSL_REC_IDLE;
                end
            end
            default: begin
                rec_state_nxt = `VPSL_REC_IDLE;
            end
        endcase
    end

    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rec_state_r <= `VPSL_REC_IDLE;
            wr_ptr_r <= {IW{1'b0}};
            post_cnt_r <= {IW{1'b0}};
        end else begin
            rec_state_r <= rec_state_nxt;
            if (rec_write) begin
                wr_ptr_r <= wr_ptr_r + {{(IW-1){1'b0}}, 1'b1};
            end
            if (rec_state_r == `VPSL_REC_IDLE) begin
                post_cnt_r <= rec_post_r; // [RQ14]
            end else if (rec_state_r == `VPSL_REC_POST && tick_r) begin
                post_cnt_r <= post_cnt_r - {{(IW-1){1'b0}}, 1'b1}; // [RQ14]
            end
        end
    end

    always @(posedge MCLK) begin
        if (rec_write) begin
            mem[wr_ptr_r] <= {starts, U12_IN, U0_IN}; // [RQ13]
        end
    end

    // Serial readout port, indexed from the oldest sample. [RQ15]
    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ser_data_r <= 32'h00000000;
        end else begin
            ser_data_r <= {{(32-EW){1'b0}}, mem[ser_slot]};
        end
    end

    assign SER_DATA = ser_data_r;
    assign REC_ACTIVE = rec_state_r == `VPSL_REC_POST;
    assign REC_STORED = rec_state_r == `VPSL_REC_DONE;

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    wire [31:0] status = {15'h0000, uv_dead_block, REC_STORED, REC_ACTIVE, fault_r, relay_r,
        uv_trip, uv_start, ov_trip, ov_start, hs_trip, hs_start, ls_trip, ls_start};

    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_r <= 32'h00000000;
        end else if (RD) begin
            case (ADDR)
                `VPSL_OFS_CTRL: rdata_r <= {24'h000000, ctrl_r};
                `VPSL_OFS_ROUTE: rdata_r <= {24'h000000, route_r};
                `VPSL_OFS_LS_THR: rdata_r <= {{(32-VW){1'b0}}, ls_thr_r};
                `VPSL_OFS_LS_TIME: rdata_r <= {{(32-TW){1'b0}}, ls_time_r};
                `VPSL_OFS_HS_THR: rdata_r <= {{(32-VW){1'b0}}, hs_thr_r};
                `VPSL_OFS_HS_TIME: rdata_r <= {{(32-TW){1'b0}}, hs_time_r};
                `VPSL_OFS_OV_THR: rdata_r <= {{(32-VW){1'b0}}, ov_thr_r};
                `VPSL_OFS_OV_TIME: rdata_r <= {{(32-TW){1'b0}}, ov_time_r};
                `VPSL_OFS_UV_THR: rdata_r <= {{(32-VW){1'b0}}, uv_thr_r};
                `VPSL_OFS_UV_TIME: rdata_r <= {{(32-TW){1'b0}}, uv_time_r};
                `VPSL_OFS_NOMINAL: rdata_r <= {{(32-VW){1'b0}}, nominal_r};
                `VPSL_OFS_STATUS: rdata_r <= status;
                `VPSL_OFS_REC_TRIG: rdata_r <= {{(24-IW){1'b0}}, rec_post_r, 4'h0, rec_trig_r};
                `VPSL_OFS_REC_CTRL: rdata_r <= {30'h00000000, rec_state_r};
                `VPSL_OFS_REC_IDX: rdata_r <= {{(32-IW){1'b0}}, rec_idx_r};
                `VPSL_OFS_REC_DATA: rdata_r <= {{(32-EW){1'b0}}, mem[rd_slot]}; // [RQ15]
                default: rdata_r <= 32'h00000000;
            endcase
        end else begin
            rdata_r <= 32'h00000000;
        end
    end

    assign RDATA = rdata_r;
endmodule

// file: vpsl_chk.sv
// Port checker for the voltage protection stage logic.
`timescale 1ns/100ps
`include "vpsl_defines.vh"
module vpsl_chk #(
    parameter VW = 12,
    parameter TW = 16,
    parameter [23:0] TICK_CYCLES = 4
) (
    input wire MCLK,
    input wire ARST_N,
    input wire [7:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire [VW-1:0] U0_IN,
    input wire EXTERNAL_BLOCK_IN,
    input wire INTERNAL_FAULT_IN,
    input wire RESIDUAL_LOW_START_OUT,
    input wire RESIDUAL_LOW_TRIP_OUT,
    input wire RESIDUAL_HIGH_START_OUT,
    input wire RESIDUAL_HIGH_TRIP_OUT,
    input wire OVERVOLTAGE_START_OUT,
    input wire OVERVOLTAGE_TRIP_OUT,
    input wire UNDERVOLTAGE_START_OUT,
    input wire UNDERVOLTAGE_TRIP_OUT,
    input wire RELAY_A,
    input wire RELAY_B,
    input wire RELAY_C,
    input wire RELAY_D,
    input wire RELAY_E,
    input wire SUPV_NORMAL_CLOSED,
    input wire SUPV_FAULT_CLOSED,
    input wire INTERNAL_FAULT_ALARM
);
    reg [1:0] up_r;
    reg [VW-1:0] ls_thr_r;
    reg [TW-1:0] ls_time_r;
    reg blk_en_r;
    reg [31:0] ls_cnt_r;
    wire ok = up_r[1];
    wire [3:0] st = {UNDERVOLTAGE_START_OUT, OVERVOLTAGE_START_OUT, RESIDUAL_HIGH_START_OUT, RESIDUAL_LOW_START_OUT};
    wire [3:0] tr = {UNDERVOLTAGE_TRIP_OUT, OVERVOLTAGE_TRIP_OUT, RESIDUAL_HIGH_TRIP_OUT, RESIDUAL_LOW_TRIP_OUT};
    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            up_r <= 2'h0;
            ls_thr_r <= `VPSL_RST_LS_THR;
            ls_time_r <= `VPSL_RST_TIME;
            blk_en_r <= 1'b0;
            ls_cnt_r <= 32'h0;
        end else begin
            up_r <= up_r + {1'b0, ~up_r[1]};
            ls_cnt_r <= RESIDUAL_LOW_START_OUT ? ls_cnt_r + 32'h1 : 32'h0;
            if (WR && ADDR == `VPSL_OFS_LS_THR) ls_thr_r <= WDATA[VW-1:0];
            if (WR && ADDR == `VPSL_OFS_LS_TIME) ls_time_r <= WDATA[TW-1:0];
            if (WR && ADDR == `VPSL_OFS_CTRL) blk_en_r <= WDATA[`VPSL_CTRL_SGB5_BIT];
        end
    end
    default clocking dc @(posedge MCLK);
    endclocking
    default disable iff (!ARST_N);
    ls_start_a: assert property (ok |-> RESIDUAL_LOW_START_OUT == $past(U0_IN > ls_thr_r))
        else $error("low-set start wrong");
    ls_early_a: assert property (RESIDUAL_LOW_TRIP_OUT |->
        ls_cnt_r + TICK_CYCLES + 2 >= ls_time_r * TICK_CYCLES)
        else $error("low-set trip too early");
    ls_late_a: assert property (st[0] && ls_cnt_r > (ls_time_r + 1) * TICK_CYCLES + 2 |-> tr[0])
        else $error("low-set trip too late");
    relay_a_a: assert property (ok |-> RELAY_A == $past(|tr))
        else $error("relay A wrong");
    relay_b_a: assert property ($past(RESIDUAL_HIGH_TRIP_OUT) |-> RELAY_B)
        else $error("relay B missed high-set trip");
    relay_cde_a: assert property (ok |-> (RELAY_C || !$past(tr[2])) && (RELAY_D || !$past(tr[3]))
        && (RELAY_E || !$past(tr[0])))
        else $error("relay C D or E missed");
    uv_block_a: assert property (blk_en_r && EXTERNAL_BLOCK_IN &&
        $past(blk_en_r && EXTERNAL_BLOCK_IN) |-> !tr[3])
        else $error("blocked undervoltage trip");
    trip_start_a: assert property ((tr & ~st) == 4'h0)
        else $error("trip without start");
    supv_a: assert property (ok |-> SUPV_FAULT_CLOSED == $past(INTERNAL_FAULT_IN)
        && SUPV_NORMAL_CLOSED == !SUPV_FAULT_CLOSED && INTERNAL_FAULT_ALARM == SUPV_FAULT_CLOSED)
        else $error("supervision contacts wrong");
endmodule
bind vpsl_top vpsl_chk #(.VW(VW), .TW(TW), .TICK_CYCLES(TICK_CYCLES)) vpsl_chk_inst (.*);

// file: vpsl_plant.sv
// Breaker trip circuit driven by the heavy-duty trip relay.
`timescale 1ns/100ps
module vpsl_plant #(
    parameter OPEN_CYCLES = 2
) (
    input wire clk,
    input wire rst_n,
    input wire trip_coil,
    output reg breaker_open_r
);
    reg [7:0] coil_cnt_r;
    // Opens once the coil has been held for the mechanism time.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coil_cnt_r <= 8'h00;
            breaker_open_r <= 1'b0;
        end else begin
            coil_cnt_r <= trip_coil ? coil_cnt_r + 8'h01 : 8'h00;
            if (coil_cnt_r >= OPEN_CYCLES) breaker_open_r <= 1'b1;
        end
    end
endmodule

// file: vpsl_top_bench.sv
// Self-checking bench for the voltage protection stage logic.
`timescale 1ns/100ps
`include "vpsl_defines.vh"
module vpsl_top_bench;
    reg MCLK = 1'b0;
    reg ARST_N = 1'b0;
    reg [7:0] ADDR = 8'h00;
    reg [31:0] WDATA = 32'h0;
    reg WR = 1'b0, RD = 1'b0;
    reg [11:0] U0_IN = 12'h000;
    reg [11:0] U12_IN = 12'h800, U23_IN = 12'h800, U31_IN = 12'h800;
    reg EXTERNAL_BLOCK_IN = 1'b0, INTERNAL_FAULT_IN = 1'b0;
    reg [3:0] SER_IDX = 4'h0;
    wire [31:0] RDATA;
    wire [31:0] SER_DATA;
    wire RESIDUAL_LOW_START_OUT, RESIDUAL_LOW_TRIP_OUT, RESIDUAL_HIGH_START_OUT, RESIDUAL_HIGH_TRIP_OUT;
    wire OVERVOLTAGE_START_OUT, OVERVOLTAGE_TRIP_OUT, UNDERVOLTAGE_START_OUT, UNDERVOLTAGE_TRIP_OUT;
    wire RELAY_A, RELAY_B, RELAY_C, RELAY_D, RELAY_E;
    wire SUPV_NORMAL_CLOSED, SUPV_FAULT_CLOSED, INTERNAL_FAULT_ALARM, REC_ACTIVE, REC_STORED;
    wire breaker_open;
    wire [3:0] st = {UNDERVOLTAGE_START_OUT, OVERVOLTAGE_START_OUT, RESIDUAL_HIGH_START_OUT, RESIDUAL_LOW_START_OUT};
    wire [3:0] tr = {UNDERVOLTAGE_TRIP_OUT, OVERVOLTAGE_TRIP_OUT, RESIDUAL_HIGH_TRIP_OUT, RESIDUAL_LOW_TRIP_OUT};
    wire [4:0] rly = {RELAY_E, RELAY_D, RELAY_C, RELAY_B, RELAY_A};
    wire [14:0] obs = {REC_STORED, REC_ACTIVE, rly, tr, st};
    wire [2:0] supv = {SUPV_NORMAL_CLOSED, SUPV_FAULT_CLOSED, INTERNAL_FAULT_ALARM};
    localparam [19:0] MASKS = {5'h0B, 5'h07, 5'h03, 5'h11};
    localparam [31:0] ROUTES = {8'h50, 8'hA0, 8'h0F, 8'hFF};
    reg [15:0] rv [0:11] = '{16'h0, 16'hFF, 16'h200, 16'h64, 16'h600, 16'h64, 16'hA00, 16'h64, 16'h600, 16'h64,
        16'h800, 16'h0};
    integer errors = 0, comparisons = 0;
    integer s, n, k;
    reg [7:0] rt;
    reg hit;

    always #2.5 MCLK = ~MCLK;

    vpsl_top #(.TICK_CYCLES(24'h000004)) vpsl_top_inst (.*);
    vpsl_plant #(.OPEN_CYCLES(2)) vpsl_plant_inst (.clk(MCLK), .rst_n(ARST_N), .trip_coil(RELAY_A),
        .breaker_open_r(breaker_open));

    task close_out;
        if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input [31:0] seen, exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            errors = errors + 1;
        end
    endtask
    task cyc(input integer c);
        repeat (c) @(posedge MCLK);
        #1;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge MCLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask
    task rd(input [7:0] a, input [31:0] e);
        @(posedge MCLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD <= 1'b0;
        #1;
        chk("rdata", RDATA, e);
    endtask
    task cond(input integer sg, input on);
        @(posedge MCLK);
        case (sg)
            0: U0_IN <= on ? 12'h300 : 12'h000;
            1: U0_IN <= on ? 12'h700 : 12'h000;
            2: U12_IN <= on ? 12'hB00 : 12'h800;
            default: U23_IN <= on ? 12'h500 : 12'h800;
        endcase
    endtask
    task wait_bit(input integer i);
        n = 0;
        while (obs[i] !== 1'b1 && n < 300) begin
            cyc(1);
            n = n + 1;
        end
        if (n >= 300) begin
            chk("wait", i, 32'hFFFF);
            close_out;
        end
    endtask

    initial begin
        repeat (3) @(posedge MCLK);
        ARST_N <= 1'b1;
        cyc(1);
        chk("supv reset", supv, 3'b100);
        wr(8'h40, 32'hFFFFFFFF);
        for (k = 0; k < 12; k = k + 1) rd(k < 11 ? {k[5:0], 2'b00} : 8'h40, {16'h0, rv[k]});
        for (k = 12; k < 40; k = k + 8) wr(k[7:0], 32'h2);
        for (s = 0; s < 4; s = s + 1) begin
            cond(s, 1'b1);
            cyc(1);
            chk("start", {st[s], tr[s]}, 2'b10);
            wait_bit(4 + s);
            chk("trip delay", n >= 4 && n <= 13, 1'b1);
            cyc(1);
            chk("relays", rly & MASKS[s*5 +: 5], MASKS[s*5 +: 5]);
            cond(s, 1'b0);
            cyc(1);
            chk("release", {st[s], tr[s]}, 2'b00);
            cyc(1);
        end
        wr(`VPSL_OFS_LS_TIME, 32'h3);
        cond(0, 1'b1);
        cyc(4);
        cond(0, 1'b0);
        hit = 1'b0;
        for (k = 0; k < 20; k = k + 1) begin
            cyc(1);
            hit = hit | tr[0];
        end
        chk("aborted trip", hit, 1'b0);
        cond(0, 1'b1);
        cyc(1);
        wait_bit(4);
        chk("timer cleared", n >= 8, 1'b1);
        cond(0, 1'b0);
        for (k = 0; k < 4; k = k + 1) begin
            rt = ROUTES[k*8 +: 8];
            wr(`VPSL_OFS_ROUTE, {24'h0, rt});
            cond(3, 1'b1);
            cyc(2);
            chk("uv start to D", RELAY_D, rt[7]);
            wait_bit(7);
            cyc(1);
            chk("uv trip to B", RELAY_B, rt[5]);
            cond(3, 1'b0);
            cond(2, 1'b1);
            cyc(2);
            chk("ov start to B", RELAY_B, rt[6]);
            wait_bit(6);
            cyc(1);
            chk("ov trip to B", RELAY_B, rt[4] | rt[6]);
            cond(2, 1'b0);
            cyc(2);
        end
        wr(`VPSL_OFS_ROUTE, 32'hFF);
        wr(`VPSL_OFS_CTRL, 32'h1);
        {U12_IN, U23_IN, U31_IN} <= {3{12'h100}};
        cyc(12);
        chk("dead block", {st[3], tr[3]}, 2'b00);
        @(posedge MCLK);
        U12_IN <= 12'h199;
        cyc(2);
        chk("dead limit", st[3], 1'b1);
        @(posedge MCLK);
        {U12_IN, U23_IN, U31_IN} <= {3{12'h800}};
        wr(`VPSL_OFS_CTRL, 32'h10);
        EXTERNAL_BLOCK_IN <= 1'b1;
        cond(3, 1'b1);
        cyc(24);
        chk("blocked trip", {st[3], tr[3], RELAY_A}, 3'b100);
        wr(`VPSL_OFS_CTRL, 32'h0);
        #1;
        wait_bit(7);
        chk("unblocked trip", n <= 3, 1'b1);
        cond(3, 1'b0);
        EXTERNAL_BLOCK_IN <= 1'b0;
        INTERNAL_FAULT_IN <= 1'b1;
        cyc(2);
        chk("fault contacts", supv, 3'b011);
        @(posedge MCLK);
        INTERNAL_FAULT_IN <= 1'b0;
        cyc(2);
        chk("healthy contacts", supv, 3'b100);
        wait_bit(14);
        rd(`VPSL_OFS_REC_CTRL, 32'h2);
        wr(`VPSL_OFS_REC_CTRL, 32'h1);
        rd(`VPSL_OFS_REC_CTRL, 32'h0);
        wr(`VPSL_OFS_REC_TRIG, 32'h201);
        cond(2, 1'b1);
        cyc(64);
        chk("masked start", REC_ACTIVE, 1'b0);
        cond(0, 1'b1);
        wait_bit(14);
        chk("post length", n >= 8 && n <= 20, 1'b1);
        wr(`VPSL_OFS_REC_IDX, 32'h0);
        rd(`VPSL_OFS_REC_DATA, 32'h04B00000);
        wr(`VPSL_OFS_REC_IDX, 32'hF);
        rd(`VPSL_OFS_REC_DATA, 32'h05B00300);
        chk("serial readout", SER_DATA, 32'h04B00000);
        chk("breaker", breaker_open, 1'b1);
        cond(0, 1'b0);
        cond(2, 1'b0);
        cyc(2);
        close_out;
    end
endmodule
